// ===== usart_params.svh
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH

// Register offsets on the eight-bit register port.
`define OFS_PERIPH_INT_FLAGS 8'h0c
`define OFS_RECEIVE_STATUS_CONTROL 8'h18
`define OFS_TRANSMIT_BUFFER 8'h19
`define OFS_RECEIVE_BUFFER 8'h1a
`define OFS_PERIPH_INT_ENABLES 8'h8c
`define OFS_TRANSMIT_STATUS_CONTROL 8'h98
`define OFS_BAUD_DIVISOR 8'h99

// Transmit status and control field positions.
`define TX_CLOCK_SOURCE_MASTER 7
`define TX_NINE_BIT_SEL 6
`define TX_TRANSMIT_ENABLE 5
`define TX_SYNC_SEL 4
`define TX_HIGH_SPEED_SEL 2
`define TX_SHIFTER_EMPTY 1
`define TX_NINTH_BIT 0

// Receive status and control field positions.
`define RX_PORT_ENABLE 7
`define RX_NINE_BIT_SEL 6
`define RX_SINGLE_RX_EN 5
`define RX_CONTINUOUS_RX_EN 4
`define RX_ADDRESS_DETECT_EN 3
`define RX_FRAMING_ERROR 2
`define RX_OVERRUN_ERROR 1
`define RX_NINTH_BIT 0

// Flag and enable positions shared by the flag and enable registers.
`define INT_RX_COMPLETE 5
`define INT_TX_EMPTY 4

// Reset values.
`define RESET_BYTE 8'h00
`define TRANSMIT_STATUS_RESET 8'h02

// Timing counts: sixteen samples per bit, start checked mid-bit,
// and a divide by four turning the slow generator rate into samples.
`define SAMPLE_LAST 4'hf
`define SAMPLE_MID 4'h7
`define LOW_SPEED_PRESCALE_LAST 2'h3
`define CLOCK_HALF_LAST 3'h7
`define FRAME_BITS_EIGHT 4'ha
`define FRAME_BITS_NINE 4'hb

`endif

// ===== usart_pkg.sv
package usart_pkg;

  // Transmit engine states.
  typedef enum logic [1:0] {
    tx_idle = 2'b00,
    tx_shift = 2'b01
  } tx_state_t;

  // Receive engine states.
  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_start = 2'b01,
    rx_data = 2'b10,
    rx_stop = 2'b11
  } rx_state_t;

endpackage

// ===== serial_link_if.sv
interface serial_link_if;
  // Device transmit line towards the remote end; idles high.
  logic tx_line;
  // Remote transmit line towards the device receiver; idles high.
  logic rx_line;
  // Shift clock driven by the device in synchronous master mode.
  logic ck_line;
  // High while the device drives the shift clock.
  logic ck_oe;

  modport device (output tx_line, input rx_line, output ck_line, output ck_oe);
  modport remote (input tx_line, output rx_line, input ck_line, input ck_oe);
endinterface

// ===== usart_remote.sv
`include "usart_params.svh"

module usart_remote (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Line setup: mclk cycles per bit and frame width.
  input wire logic [15:0] bit_cycles,
  input wire logic nine_bit_mode,
  // Send side.
  input wire logic [8:0] send_word,
  input wire logic send_valid,
  output logic send_ready,
  // Receive side.
  output logic [8:0] recv_word,
  output logic recv_valid,
  output logic recv_frame_error,
  // Serial link.
  serial_link_if.remote link
);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  usart_pkg::tx_state_t tx_state; // Sender state.
  logic [10:0] tx_frame; // Frame bits, start bit first at bit 0.
  logic [3:0] tx_bits_left; // Bits still to send, current one included.
  logic [15:0] tx_count; // Cycles spent in the current bit.
  logic tx_out; // Line level, from a flop.

  wire tx_bit_end = (tx_count == bit_cycles - 16'h0001);
  wire send_take = send_ready && send_valid;

  // The line idles high; a frame is start, data LSb first, ninth in nine-bit mode, stop.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_state <= usart_pkg::tx_idle;
      tx_frame <= 11'h7ff;
      tx_bits_left <= 4'h0;
      tx_count <= 16'h0000;
      tx_out <= 1'b1;
      send_ready <= 1'b1;
    end else if (ce) begin
      case (tx_state)
        usart_pkg::tx_idle: begin
          if (send_take) begin
            // Stop bit sits above the data, or above the ninth bit.
            tx_frame <= nine_bit_mode ? {1'b1, send_word, 1'b0}
                                      : {2'b11, send_word[7:0], 1'b0};
            tx_bits_left <= nine_bit_mode ? `FRAME_BITS_NINE : `FRAME_BITS_EIGHT;
            tx_count <= 16'h0000;
            tx_out <= 1'b0;
            send_ready <= 1'b0;
            tx_state <= usart_pkg::tx_shift;
          end
        end
        default: begin
          if (tx_bit_end) begin
            tx_count <= 16'h0000;
            if (tx_bits_left == 4'h1) begin
              tx_out <= 1'b1;
              send_ready <= 1'b1;
              tx_state <= usart_pkg::tx_idle;
            end else begin
              tx_frame <= {1'b1, tx_frame[10:1]};
              tx_out <= tx_frame[1];
              tx_bits_left <= tx_bits_left - 4'h1;
            end
          end else begin
            tx_count <= tx_count + 16'h0001;
          end
        end
      endcase
    end
  end

  assign link.rx_line = tx_out;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver. The device line is on the same clock, so no synchroniser.

  usart_pkg::rx_state_t rx_state; // Receiver state.
  logic rx_prev; // Line level one cycle ago, for the falling edge.
  logic [15:0] rx_count; // Cycles within the current bit.
  logic [3:0] rx_bits_left; // Data bits still to take.
  logic [8:0] rx_shift; // Data bits, shifted in from the top.

  wire rx_fall = rx_prev && !link.tx_line;
  wire rx_half = (rx_count == {1'b0, bit_cycles[15:1]});
  wire rx_full = (rx_count == bit_cycles - 16'h0001);

  // Sample each bit in its middle; the start bit is checked once.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_state <= usart_pkg::rx_idle;
      rx_prev <= 1'b1;
      rx_count <= 16'h0000;
      rx_bits_left <= 4'h0;
      rx_shift <= 9'h000;
      recv_word <= 9'h000;
      recv_valid <= 1'b0;
      recv_frame_error <= 1'b0;
    end else if (ce) begin
      rx_prev <= link.tx_line;
      recv_valid <= 1'b0;
      case (rx_state)
        usart_pkg::rx_idle: begin
          rx_count <= 16'h0000;
          if (rx_fall) begin
            rx_state <= usart_pkg::rx_start;
          end
        end
        usart_pkg::rx_start: begin
          rx_count <= rx_count + 16'h0001;
          if (rx_half) begin
            // A glitch that is high again mid-bit is not a start.
            rx_count <= 16'h0000;
            rx_bits_left <= nine_bit_mode ? 4'h9 : 4'h8;
            rx_state <= link.tx_line ? usart_pkg::rx_idle : usart_pkg::rx_data;
          end
        end
        usart_pkg::rx_data: begin
          rx_count <= rx_count + 16'h0001;
          if (rx_full) begin
            rx_count <= 16'h0000;
            rx_shift <= {link.tx_line, rx_shift[8:1]};
            rx_bits_left <= rx_bits_left - 4'h1;
            if (rx_bits_left == 4'h1) begin
              rx_state <= usart_pkg::rx_stop;
            end
          end
        end
        default: begin
          rx_count <= rx_count + 16'h0001;
          if (rx_full) begin
            recv_word <= nine_bit_mode ? rx_shift : {1'b0, rx_shift[8:1]};
            recv_frame_error <= !link.tx_line;
            recv_valid <= 1'b1;
            rx_state <= usart_pkg::rx_idle;
          end
        end
      endcase
    end
  end

endmodule

// ===== usart_device.sv
// Local design decision: the strobed register port.
`include "usart_params.svh"

// Operation
// - Frame: start, eight/nine data, one stop.
// - LSb first; shared format and bit rate.
// - Bit timing from eight-bit baud divisor.
// - High speed selects sixteen, else sixty-four.
// - Sync select clear means asynchronous; no parity.
// - Shifter reloads only after stop bit.
// - Transfer sets the transmit empty flag.
// - Flag sets regardless of its enable.
// - Only a buffer write clears that flag.
// - Read-only shifter empty status bit.
// - Transmit enable sets the empty flag.
// - Software configures, then writes the buffer.
// - Ninth transmit bit set before loading.
// - Receiver samples sixteen times per bit.
// - Nine-bit receive stores the ninth bit.
// - Address frames load and flag at stop.
// - Address detect drops data frames silently.
// - Address detect only in nine-bit mode.
// - Continuous receive enable starts reception.
// - Receive complete flag set on load.
// - Clearing continuous receive clears errors.
// - Sync master drives clock, half-duplex; the code drives only the clock, with no sync data.
module usart_device (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Flag gated by its enable, for the interrupt controller outside.
  output logic irq_req,
  // Serial link.
  serial_link_if.device link
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and address decode.

  logic [7:0] periph_int_enables; // Interrupt enables, fully writable.
  logic [7:0] tx_ctrl; // Writable fields of the transmit status register.
  logic [7:0] rx_ctrl; // Writable fields of the receive status register.
  logic [7:0] transmit_buffer; // Word waiting for the shifter.
  logic [7:0] receive_buffer; // Last word accepted.
  logic [7:0] baud_divisor; // Generator reload value.
  logic tx_empty_flag; // Transmit buffer can take a word.
  logic rx_complete_flag; // Receive buffer holds an unread word.
  logic framing_error; // Stop bit of the last word was low.
  logic overrun_error; // A word arrived while the buffer was unread.
  logic rx_ninth_bit; // Ninth bit of the last word.
  logic shifter_empty; // Transmit shifter idle.

  wire wr_enables = wr && (addr == `OFS_PERIPH_INT_ENABLES);
  wire wr_tx_ctrl = wr && (addr == `OFS_TRANSMIT_STATUS_CONTROL);
  wire wr_rx_ctrl = wr && (addr == `OFS_RECEIVE_STATUS_CONTROL);
  wire wr_txbuf = wr && (addr == `OFS_TRANSMIT_BUFFER);
  wire wr_divisor = wr && (addr == `OFS_BAUD_DIVISOR);
  wire rd_rxbuf = rd && (addr == `OFS_RECEIVE_BUFFER);

  wire port_enable = rx_ctrl[`RX_PORT_ENABLE];
  wire sync_sel = tx_ctrl[`TX_SYNC_SEL];
  wire transmit_enable = tx_ctrl[`TX_TRANSMIT_ENABLE];
  wire continuous_rx_en = rx_ctrl[`RX_CONTINUOUS_RX_EN];
  wire rx_nine_bit_sel = rx_ctrl[`RX_NINE_BIT_SEL];
  // The engines run only in asynchronous mode with the port enabled.
  wire async_on = port_enable && !sync_sel;

  // Read mux; status bits are assembled from live state.
  logic [7:0] read_mux;
  always_comb begin
    if (addr == `OFS_PERIPH_INT_FLAGS) begin
      read_mux = `RESET_BYTE;
      read_mux[`INT_RX_COMPLETE] = rx_complete_flag;
      read_mux[`INT_TX_EMPTY] = tx_empty_flag;
    end else if (addr == `OFS_RECEIVE_STATUS_CONTROL) begin
      read_mux = rx_ctrl;
      read_mux[`RX_FRAMING_ERROR] = framing_error;
      read_mux[`RX_OVERRUN_ERROR] = overrun_error;
      read_mux[`RX_NINTH_BIT] = rx_ninth_bit;
    end else if (addr == `OFS_TRANSMIT_BUFFER) begin
      read_mux = transmit_buffer;
    end else if (addr == `OFS_RECEIVE_BUFFER) begin
      read_mux = receive_buffer;
    end else if (addr == `OFS_PERIPH_INT_ENABLES) begin
      read_mux = periph_int_enables;
    end else if (addr == `OFS_TRANSMIT_STATUS_CONTROL) begin
      read_mux = tx_ctrl;
      read_mux[`TX_SHIFTER_EMPTY] = shifter_empty;
    end else if (addr == `OFS_BAUD_DIVISOR) begin
      read_mux = baud_divisor;
    end else begin
      read_mux = `RESET_BYTE;
    end
  end

  // Software fields. Status bits inside the control bytes are never stored
  // here, so writes to them are ignored.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      periph_int_enables <= `RESET_BYTE;
      tx_ctrl <= `RESET_BYTE;
      rx_ctrl <= `RESET_BYTE;
      baud_divisor <= `RESET_BYTE;
      transmit_buffer <= `RESET_BYTE;
      rdata <= `RESET_BYTE;
    end else if (ce) begin
      rdata <= rd ? read_mux : `RESET_BYTE;
      if (wr_enables) begin
        periph_int_enables <= wdata;
      end
      if (wr_tx_ctrl) begin
        tx_ctrl <= wdata & 8'hf5;
      end
      if (wr_rx_ctrl) begin
        rx_ctrl <= wdata & 8'hf8;
      end
      if (wr_divisor) begin
        baud_divisor <= wdata;
      end
      if (wr_txbuf) begin
        transmit_buffer <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator and sample tick.

  logic [7:0] brg_count; // Down counter reloaded from the divisor.
  logic [1:0] prescale; // Divides the slow rate down to samples.
  wire brg_tick = port_enable && (brg_count == 8'h00);
  // One bit is always sixteen sample ticks, so the slow rate is quartered.
  wire sample_tick = brg_tick &&
    (tx_ctrl[`TX_HIGH_SPEED_SEL] || prescale == `LOW_SPEED_PRESCALE_LAST);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      brg_count <= 8'h00;
      prescale <= 2'h0;
    end else if (ce) begin
      if (!port_enable) begin
        brg_count <= baud_divisor;
        prescale <= 2'h0;
      end else if (brg_tick) begin
        brg_count <= baud_divisor;
        prescale <= prescale + 2'h1;
      end else begin
        brg_count <= brg_count - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  usart_pkg::tx_state_t tx_state; // Transmit engine state.
  logic [10:0] tx_shifter; // Frame bits, current bit at bit 0.
  logic [3:0] tx_bits_left; // Bits still to send, current included.
  logic [3:0] tx_samples; // Sample ticks within the current bit.
  logic tx_buf_full; // Buffer holds a word not yet taken.
  logic transmit_enable_prev; // Enable one cycle ago, for its rising edge.
  logic tx_out; // Line level, from a flop.

  // A write in the same cycle wins; the transfer simply waits one cycle
  // so the flag never disagrees with the buffer.
  wire tx_go = (tx_state == usart_pkg::tx_idle) && tx_buf_full && transmit_enable &&
               async_on && !wr_txbuf;
  wire tx_bit_end = sample_tick && (tx_samples == `SAMPLE_LAST);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_state <= usart_pkg::tx_idle;
      tx_shifter <= 11'h7ff;
      tx_bits_left <= 4'h0;
      tx_samples <= 4'h0;
      tx_out <= 1'b1;
    end else if (ce) begin
      case (tx_state)
        usart_pkg::tx_idle: begin
          tx_out <= 1'b1;
          tx_samples <= 4'h0;
          if (tx_go) begin
            tx_shifter <= {1'b1, tx_ctrl[`TX_NINE_BIT_SEL] ? tx_ctrl[`TX_NINTH_BIT] : 1'b1,
                           transmit_buffer, 1'b0};
            tx_bits_left <= tx_ctrl[`TX_NINE_BIT_SEL] ? `FRAME_BITS_NINE : `FRAME_BITS_EIGHT;
            tx_out <= 1'b0;
            tx_state <= usart_pkg::tx_shift;
          end
        end
        default: begin
          if (sample_tick) begin
            tx_samples <= tx_samples + 4'h1;
          end
          if (tx_bit_end) begin
            if (tx_bits_left == 4'h1) begin
              tx_state <= usart_pkg::tx_idle;
            end else begin
              tx_shifter <= {1'b1, tx_shifter[10:1]};
              tx_out <= tx_shifter[1];
              tx_bits_left <= tx_bits_left - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Buffer occupancy and the two transmit status bits.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_buf_full <= 1'b0;
      tx_empty_flag <= 1'b0;
      transmit_enable_prev <= 1'b0;
      shifter_empty <= 1'b1;
    end else if (ce) begin
      transmit_enable_prev <= transmit_enable;
      shifter_empty <= (tx_state == usart_pkg::tx_idle) && !tx_go;
      if (wr_txbuf) begin
        tx_buf_full <= 1'b1;
      end else if (tx_go) begin
        tx_buf_full <= 1'b0;
      end
      // Set wins; the flag register itself is never written.
      if (tx_go || (transmit_enable && !transmit_enable_prev)) begin
        tx_empty_flag <= 1'b1;
      end else if (wr_txbuf) begin
        tx_empty_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver.

  logic rx_sync1; // First synchroniser stage, read by the second only.
  logic rx_sync2; // Second stage.
  logic rx_sync3; // Third stage.
  logic rx_level; // Filtered line level.
  logic rx_level_prev; // Filtered level one cycle ago.
  usart_pkg::rx_state_t rx_state; // Receive engine state.
  logic [3:0] rx_samples; // Sample ticks within the current bit.
  logic [3:0] rx_bits_left; // Data bits still to take.
  logic [8:0] rx_shifter; // Data bits, shifted in from the top.

  wire rx_run = async_on && continuous_rx_en;
  wire rx_fall = rx_level_prev && !rx_level;
  wire rx_ninth = rx_shifter[8];
  // Data frames are dropped only when nine-bit mode and detect are both on.
  wire rx_drop = rx_nine_bit_sel && rx_ctrl[`RX_ADDRESS_DETECT_EN] && !rx_ninth;
  // A frame cut short by clearing the receive enable must not load or flag.
  wire rx_stop_end = rx_run && (rx_state == usart_pkg::rx_stop) && sample_tick &&
                     (rx_samples == `SAMPLE_LAST);
  wire rx_load = rx_stop_end && !rx_drop && !rx_complete_flag;

  // Pin synchroniser; a change counts once stages two and three agree.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      rx_sync3 <= 1'b1;
      rx_level <= 1'b1;
      rx_level_prev <= 1'b1;
    end else if (ce) begin
      rx_sync1 <= link.rx_line;
      rx_sync2 <= rx_sync1;
      rx_sync3 <= rx_sync2;
      rx_level_prev <= rx_level;
      if (rx_sync2 == rx_sync3) begin
        rx_level <= rx_sync3;
      end
    end
  end

  // Frame engine: mid-start check at sample seven, then sixteen per bit.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_state <= usart_pkg::rx_idle;
      rx_samples <= 4'h0;
      rx_bits_left <= 4'h0;
      rx_shifter <= 9'h000;
    end else if (ce) begin
      if (sample_tick) begin
        rx_samples <= rx_samples + 4'h1;
      end
      case (rx_state)
        usart_pkg::rx_idle: begin
          rx_samples <= 4'h0;
          if (rx_run && rx_fall) begin
            rx_state <= usart_pkg::rx_start;
          end
        end
        usart_pkg::rx_start: begin
          if (sample_tick && rx_samples == `SAMPLE_MID) begin
            rx_samples <= 4'h0;
            rx_bits_left <= rx_nine_bit_sel ? 4'h9 : 4'h8;
            rx_state <= rx_level ? usart_pkg::rx_idle : usart_pkg::rx_data;
          end
        end
        usart_pkg::rx_data: begin
          if (sample_tick && rx_samples == `SAMPLE_LAST) begin
            rx_shifter <= {rx_level, rx_shifter[8:1]};
            rx_bits_left <= rx_bits_left - 4'h1;
            if (rx_bits_left == 4'h1) begin
              rx_state <= usart_pkg::rx_stop;
            end
          end
        end
        default: begin
          if (rx_stop_end) begin
            rx_state <= usart_pkg::rx_idle;
          end
        end
      endcase
      if (!rx_run) begin
        rx_state <= usart_pkg::rx_idle;
      end
    end
  end

  // Receive buffer, flag and errors. An eight-bit word sits in bits 8:1.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      receive_buffer <= `RESET_BYTE;
      rx_complete_flag <= 1'b0;
      rx_ninth_bit <= 1'b0;
      framing_error <= 1'b0;
      overrun_error <= 1'b0;
    end else if (ce) begin
      if (rx_load) begin
        receive_buffer <= rx_nine_bit_sel ? rx_shifter[7:0] : rx_shifter[8:1];
        rx_ninth_bit <= rx_nine_bit_sel && rx_ninth;
        framing_error <= !rx_level;
        rx_complete_flag <= 1'b1;
      end else if (rd_rxbuf) begin
        rx_complete_flag <= 1'b0;
      end
      if (rx_stop_end && !rx_drop && rx_complete_flag) begin
        overrun_error <= 1'b1;
      end else if (!continuous_rx_en) begin
        overrun_error <= 1'b0;
        framing_error <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous master clock and interrupt request.

  logic [2:0] ck_half; // Sample ticks per half clock period.
  logic ck_out; // Shift clock level.
  logic ck_drive; // Clock pin enable.
  wire ck_master = port_enable && sync_sel && tx_ctrl[`TX_CLOCK_SOURCE_MASTER];

  // In synchronous master mode the async engines stay idle, so the line
  // carries only the clock; no data is transferred in that mode.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ck_half <= 3'h0;
      ck_out <= 1'b1;
      ck_drive <= 1'b0;
      irq_req <= 1'b0;
    end else if (ce) begin
      ck_drive <= ck_master;
      irq_req <= (tx_empty_flag && periph_int_enables[`INT_TX_EMPTY]) ||
                 (rx_complete_flag && periph_int_enables[`INT_RX_COMPLETE]);
      if (!ck_master) begin
        ck_half <= 3'h0;
        ck_out <= 1'b1;
      end else if (sample_tick) begin
        ck_half <= ck_half + 3'h1;
        if (ck_half == `CLOCK_HALF_LAST) begin
          ck_out <= !ck_out;
        end
      end
    end
  end

  assign link.tx_line = tx_out;
  assign link.ck_line = ck_out;
  assign link.ck_oe = ck_drive;

endmodule

// ===== usart_chk.sv
module usart_chk (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Serial link.
  input wire logic tx_line,
  input wire logic rx_line,
  input wire logic ck_line,
  input wire logic ck_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycle within a device frame, 0 when idle; the bench runs 16 cycles a bit.
  logic [7:0] tc;

  ////////////////////////////////////////
  // Track the device frame from its falling start edge; eight data bits only.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) tc <= 8'h00;
    else if (tc != 8'h00) tc <= (tc == 8'h9f) ? 8'h00 : tc + 8'h01;
    else if (!tx_line) tc <= 8'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // One bit time at one level: low on either line, high on the remote line only.
  sequence s_tx_lo; !tx_line [*8] ##1 !tx_line [*7]; endsequence
  sequence s_rx_lo; !rx_line [*8] ##1 !rx_line [*7]; endsequence
  sequence s_rx_hi; rx_line [*8] ##1 rx_line [*7]; endsequence

  a_tx_start_low: assert property (tc == 8'h00 && !tx_line |=> s_tx_lo)
    else $error("start bit too short");
  a_tx_stop_high: assert property (tc >= 8'h90 |-> tx_line)
    else $error("stop bit not high");
  a_tx_bit_steady: assert property (tc != 8'h00 && tc[3:0] != 4'h0 |-> $stable(tx_line))
    else $error("bit changed inside bit time");
  a_tx_start_edge: assert property (tc == 8'h01 |-> $past(tx_line, 2))
    else $error("start without falling edge");
  a_idle_after_reset: assert property ($fell(reset) |-> tx_line && rx_line)
    else $error("line not idle after reset");
  a_clock_parked: assert property (!ck_oe && ck_line)
    else $error("clock driven in asynchronous mode");
  a_rx_low_run: assert property ($fell(rx_line) |=> s_rx_lo)
    else $error("remote low bit too short");
  a_rx_high_run: assert property ($rose(rx_line) |=> s_rx_hi)
    else $error("remote high bit too short");
endmodule

// ===== usart_async_serial_port_tb.sv
module usart_async_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and register port.
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq_req;
  // Remote user side.
  logic nine = 1'b0;
  logic [8:0] send_word = 9'h000;
  logic send_valid = 1'b0;
  logic send_ready;
  logic [8:0] recv_word;
  logic recv_valid;
  logic recv_frame_error;
  int error_cnt = 0;
  int n_checks = 0;

  serial_link_if link ();
  usart_device u_usart_device (.mclk, .reset, .ce(1'b1), .addr, .wdata, .wr, .rd,
    .rdata, .irq_req, .link(link));
  // Sixteen cycles a bit matches divisor 0 with high speed set.
  usart_remote u_usart_remote (.mclk, .reset, .ce(1'b1), .bit_cycles(16'h0010),
    .nine_bit_mode(nine), .send_word, .send_valid, .send_ready, .recv_word,
    .recv_valid, .recv_frame_error, .link(link));
  usart_chk u_usart_chk (.mclk, .reset, .tx_line(link.tx_line),
    .rx_line(link.rx_line), .ck_line(link.ck_line), .ck_oe(link.ck_oe));

  ////////////////////////////////////////
  // Free-running clock of 8 ns.
  initial forever #4 mclk = ~mclk;

  task chk(input string n, input logic [8:0] s, input logic [8:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A bounded wait that ran out ends the run.
  task limit(input int i);
    if (i >= 400) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  task rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_rd(a, d);
    chk(n, {1'b0, d}, {1'b0, e});
  endtask

  // Remote offers a word until it is taken.
  task send(input logic [8:0] w);
    int i;
    @(posedge mclk);
    send_word <= w;
    send_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (send_ready !== 1'b1 && i < 400);
    limit(i);
    send_valid <= 1'b0;
  endtask

  task expect_rx(input logic [8:0] e);
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (recv_valid !== 1'b1 && i < 400);
    limit(i);
    chk("recv_word", recv_word, e);
    chk("frame_error", {8'h00, recv_frame_error}, 9'h000);
  endtask

  // Poll the receive complete flag; the transmit flag may stand beside it.
  task wait_rx_flag;
    logic [7:0] d;
    int i;
    i = 0;
    do begin
      reg_rd(8'h0c, d);
      i++;
    end while (d[5] !== 1'b1 && i < 400);
    limit(i);
    chk("rx_flag", {8'h00, d[5]}, 9'h001);
  endtask

  ////////////////////////////////////////
  // Reset values, then two buffer writes back to back with interrupt enables clear.
  task t_tx;
    rd_chk("tx_status", 8'h98, 8'h02);
    rd_chk("unmapped", 8'h40, 8'h00);
    reg_wr(8'h99, 8'h00);
    reg_wr(8'h18, 8'h90);
    reg_wr(8'h98, 8'h24);
    rd_chk("flags", 8'h0c, 8'h10);
    reg_wr(8'h19, 8'ha5);
    reg_wr(8'h19, 8'h3c);
    rd_chk("flags", 8'h0c, 8'h00);
    rd_chk("tx_status", 8'h98, 8'h24);
    expect_rx(9'h0a5);
    expect_rx(9'h03c);
    reg_wr(8'h0c, 8'h00);
    rd_chk("flags", 8'h0c, 8'h10);
    repeat (16) @(posedge mclk);
    rd_chk("tx_status", 8'h98, 8'h26);
    $display("test tx done");
  endtask

  // Eight-bit frame with address detect set, then a data and an address frame.
  task t_rx;
    reg_wr(8'h18, 8'h98);
    send(9'h05a);
    wait_rx_flag();
    rd_chk("rx_buffer", 8'h1a, 8'h5a);
    @(posedge mclk);
    nine <= 1'b1;
    reg_wr(8'h8c, 8'h20);
    reg_wr(8'h18, 8'hd8);
    send(9'h033);
    send(9'h1c7);
    wait_rx_flag();
    chk("irq_req", {8'h00, irq_req}, 9'h001);
    rd_chk("rx_status", 8'h18, 8'hd9);
    rd_chk("rx_buffer", 8'h1a, 8'hc7);
    repeat (2) @(posedge mclk);
    chk("irq_req", {8'h00, irq_req}, 9'h000);
    // Nine-bit transmit: the ninth bit is set before the buffer write.
    reg_wr(8'h98, 8'h65);
    reg_wr(8'h19, 8'h81);
    expect_rx(9'h181);
    $display("test rx done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_tx();
    t_rx();
    give_verdict();
  end
endmodule
